// ==== verilog/lcd_contrast_seg_regs.sv ====
// lcd contrast code and segment pin enable registers, avalon-mm slave
// assumes one 200 mhz clock and a master that holds its request
// until waitrequest is seen low
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "lcd_regs_defs.svh"

module lcd_contrast_seg_regs
   import lcd_regs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [`ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [`BE_W-1:0] byteenable,
   input wire logic [`DATA_W-1:0] writedata,
   output logic [`DATA_W-1:0] readdata,
   output logic [1:0] response,
   output logic waitrequest,
   output ladder_s ladder,
   input wire pin_drive_s gpio_drive,
   input wire logic [`SEG_PINS-1:0] seg_level,
   input wire logic [`SEG_PINS-1:0] pin_in,
   output pin_drive_s pad_drive,
   output logic [`SEG_PINS-1:0] gpio_in,
   output logic [`SEG_PINS-1:0] seg_pin_mask
);

   // ==========================================================
   // reset release
   logic [1:0] rst_sync_reg;
   logic rst_n_int;

   // assertion is asynchronous, release is aligned to core_clk
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n_int = rst_sync_reg[1];

   // ==========================================================
   // helper functions

   // register decode: hit flag, kind and segment index
   typedef struct packed {
      logic hit;
      logic is_contrast;
      logic is_status;
      logic [2:0] seg_idx;
   } decode_s;

   function automatic decode_s decode_addr(
      input logic [`ADDR_W-1:0] addr
   );
      decode_s d;
      logic [`ADDR_W-1:0] rel;
      d = '0;
      rel = addr - `SEG_BASE_OFS;
      if (addr == `CONTRAST_OFS) begin
         d.hit = 1'b1;
         d.is_contrast = 1'b1;
      end else if (addr == `STATUS_OFS) begin
         d.hit = 1'b1;
         d.is_status = 1'b1;
      end else if (addr >= `SEG_BASE_OFS && rel[1:0] == 2'h0 &&
                   rel[`ADDR_W-1:2] < (`ADDR_W-2)'(`SEG_REGS)) begin
         d.hit = 1'b1;
         d.seg_idx = rel[4:2];
      end
      return d;
   endfunction

   // contrast code to ladder: one series step per seventh
   function automatic ladder_s ladder_of(
      input logic [`CONTRAST_W-1:0] code
   );
      ladder_s l;
      l = '0;
      l.shorted = (code == `CONTRAST_RST);
      for (int i = 0; i < `LADDER_STEPS; i++) begin
         l.tap_en[i] = (`CONTRAST_W'(i) < code);
      end
      return l;
   endfunction

   // number of pins handed to the segment driver
   function automatic logic [`STAT_CNT_W-1:0] count_pins(
      input logic [`SEG_REGS-1:0][7:0] en
   );
      logic [`STAT_CNT_W-1:0] n;
      n = '0;
      for (int r = 0; r < `SEG_REGS; r++) begin
         for (int b = 0; b < 8; b++) begin
            n = n + `STAT_CNT_W'(en[r][b]);
         end
      end
      return n;
   endfunction

   // ==========================================================
   // state
   bank_state_s state_reg;
   bank_state_s state_next;
   decode_s dec;
   logic [`DATA_W-1:0] status_word;
   logic req;

   assign req = read | write;
   assign dec = decode_addr(address);

   // status: live ladder setting and count of segment pins
   always_comb begin
      status_word = '0;
      status_word[`STAT_TAP_LSB +: `LADDER_STEPS] = state_reg.ladder.tap_en;
      status_word[`STAT_SHORT_BIT] = state_reg.ladder.shorted;
      status_word[`STAT_CNT_LSB +: `STAT_CNT_W] = count_pins(state_reg.seg_en);
   end

   // ==========================================================
   // next state
   always_comb begin
      state_next = state_reg;
      case (state_reg.bus)
         BUS_IDLE: begin
            // one wait cycle lets read data come from a flip-flop
            if (req) begin
               state_next.bus = BUS_ACK;
               state_next.rdata = '0;
               state_next.resp = dec.hit ? `RESP_OK : `RESP_DECERR;
               if (read && dec.is_contrast) begin
                  state_next.rdata[`CONTRAST_W-1:0] = state_reg.contrast_code;
               end else if (read && dec.is_status) begin
                  state_next.rdata = status_word;
               end else if (read && dec.hit) begin
                  state_next.rdata[7:0] = state_reg.seg_en[dec.seg_idx];
               end
            end
         end
         BUS_ACK: begin
            // write lands at the edge where waitrequest is low
            state_next.bus = BUS_IDLE;
            if (write && byteenable[0] && dec.is_contrast) begin
               state_next.contrast_code = writedata[`CONTRAST_W-1:0];
            end else if (write && byteenable[0] && dec.hit &&
                         !dec.is_status) begin
               state_next.seg_en[dec.seg_idx] = writedata[7:0];
            end
         end
         default: begin
            state_next.bus = BUS_IDLE;
         end
      endcase
      state_next.ladder = ladder_of(state_next.contrast_code);
   end

   always_ff @(posedge core_clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         state_reg.bus <= BUS_IDLE;
         state_reg.contrast_code <= `CONTRAST_RST;
         state_reg.seg_en <= {`SEG_REGS{`SEG_RST}};
         state_reg.ladder.shorted <= 1'b1;
         state_reg.ladder.tap_en <= '0;
         state_reg.rdata <= '0;
         state_reg.resp <= `RESP_OK;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // outputs
   assign waitrequest = req && (state_reg.bus != BUS_ACK);
   assign readdata = state_reg.rdata;
   assign response = state_reg.resp;
   assign ladder = state_reg.ladder;
   assign seg_pin_mask = state_reg.seg_en;

   // ==========================================================
   // pin ownership
   pin_function_mux u_pin_mux (
      .seg_enable(state_reg.seg_en),
      .gpio_drive(gpio_drive),
      .seg_level(seg_level),
      .pin_in(pin_in),
      .pad_drive(pad_drive),
      .gpio_in(gpio_in)
   );

endmodule // lcd_contrast_seg_regs

// ==== include/lcd_regs_defs.svh ====
// constants of the lcd contrast and segment enable register bank
// assumes a byte-addressed avalon-mm slave with 32-bit data words
`ifndef LCD_REGS_DEFS_SVH
`define LCD_REGS_DEFS_SVH

// ==========================================================
// bus shape
`define ADDR_W 8
`define DATA_W 32
`define BE_W 4

// ==========================================================
// register offsets (byte addresses, one word each)
`define CONTRAST_OFS 8'h00
`define STATUS_OFS 8'h04
`define SEG_BASE_OFS 8'h10
`define SEG_REGS 6
`define SEG_PINS 48

// ==========================================================
// fields and reset values
`define CONTRAST_W 3
`define CONTRAST_RST 3'h0
`define SEG_RST 8'h00
`define LADDER_STEPS 7
`define STAT_TAP_LSB 0
`define STAT_SHORT_BIT 7
`define STAT_CNT_LSB 8
`define STAT_CNT_W 8

// ==========================================================
// avalon response codes
`define RESP_OK 2'h0
`define RESP_DECERR 2'h3

`endif

// ==== include/lcd_regs_pkg.sv ====
// types shared by the lcd register bank and its pin function mux
// assumes lcd_regs_defs.svh is reachable on the include path
`include "lcd_regs_defs.svh"

package lcd_regs_pkg;

   // ==========================================================
   // bus handshake states, gray along idle -> ack
   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_ACK = 2'h1
   } bus_state_e;

   // ==========================================================
   // contrast ladder drive
   typedef struct packed {
      logic shorted;
      logic [`LADDER_STEPS-1:0] tap_en;
   } ladder_s;

   // ==========================================================
   // per-pin gpio side and pad side
   typedef struct packed {
      logic [`SEG_PINS-1:0] out;
      logic [`SEG_PINS-1:0] oe_n;
   } pin_drive_s;

   // ==========================================================
   // whole state of the register bank
   typedef struct packed {
      bus_state_e bus;
      logic [`CONTRAST_W-1:0] contrast_code;
      logic [`SEG_REGS-1:0][7:0] seg_en;
      ladder_s ladder;
      logic [`DATA_W-1:0] rdata;
      logic [1:0] resp;
   } bank_state_s;

endpackage

// ==== verilog/pin_function_mux.sv ====
// hands each pin either to the lcd segment driver or to gpio
// assumes segment and gpio drive arrive synchronous to core_clk
`timescale 1ns/1ps
`include "lcd_regs_defs.svh"

module pin_function_mux
   import lcd_regs_pkg::*;
(
   input wire logic [`SEG_PINS-1:0] seg_enable,
   input wire pin_drive_s gpio_drive,
   input wire logic [`SEG_PINS-1:0] seg_level,
   input wire logic [`SEG_PINS-1:0] pin_in,
   output pin_drive_s pad_drive,
   output logic [`SEG_PINS-1:0] gpio_in
);

   // ==========================================================
   // function select per pin
   always_comb begin
      for (int i = 0; i < `SEG_PINS; i++) begin
         if (seg_enable[i]) begin
            pad_drive.out[i] = seg_level[i];
            pad_drive.oe_n[i] = 1'b0;
            // segment pins read low so gpio sees no glass waveform
            gpio_in[i] = 1'b0;
         end else begin
            pad_drive.out[i] = gpio_drive.out[i];
            pad_drive.oe_n[i] = gpio_drive.oe_n[i];
            gpio_in[i] = pin_in[i];
         end
      end
   end

endmodule // pin_function_mux

// ==== verification/lcd_regs_chk.sv ====
// checker for the lcd contrast and segment enable bank ports
// assumes the package and the defs header are compiled first
`timescale 1ns/1ps
`include "lcd_regs_defs.svh"

module lcd_regs_chk
   import lcd_regs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [`ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [`BE_W-1:0] byteenable,
   input wire logic [`DATA_W-1:0] writedata,
   input wire logic [`DATA_W-1:0] readdata,
   input wire logic waitrequest,
   input wire ladder_s ladder,
   input wire pin_drive_s gpio_drive,
   input wire logic [`SEG_PINS-1:0] seg_level,
   input wire logic [`SEG_PINS-1:0] pin_in,
   input wire pin_drive_s pad_drive,
   input wire logic [`SEG_PINS-1:0] gpio_in,
   input wire logic [`SEG_PINS-1:0] seg_pin_mask
);
   // ==========================================================
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_ladder_short: assert property (
      ladder.shorted == (ladder.tap_en == 7'h00)) else $error("short");
   a_ladder_thermo: assert property (
      ((ladder.tap_en + 7'h01) & ladder.tap_en) == 7'h00) else $error("tap");
   a_code_upper_zero: assert property (
      read && !waitrequest && address == `CONTRAST_OFS
      |-> readdata[31:3] == 29'h0) else $error("upper bits");
   a_code_ladder_match: assert property (
      read && !waitrequest && address == `CONTRAST_OFS
      |-> $countones(ladder.tap_en) == readdata[2:0]) else $error("code");
   a_code_write_lands: assert property (
      write && !waitrequest && byteenable[0] && address == `CONTRAST_OFS
      |=> $countones(ladder.tap_en) == $past(writedata[2:0]))
      else $error("code write");
   a_seg_write_lands: assert property (
      write && !waitrequest && byteenable[0] && address == `SEG_BASE_OFS
      |=> seg_pin_mask[7:0] == $past(writedata[7:0])) else $error("seg");
   a_seg_drives_pad: assert property (
      ((pad_drive.oe_n | (pad_drive.out ^ seg_level)) & seg_pin_mask)
      == 48'h0) else $error("segment pin");
   a_gpio_keeps_pin: assert property (
      (((pad_drive.out ^ gpio_drive.out) | (pad_drive.oe_n ^ gpio_drive.oe_n)
      | (gpio_in ^ pin_in)) & ~seg_pin_mask) == 48'h0) else $error("gpio");
   a_one_wait: assert property (
      (read || write) && waitrequest |=> !waitrequest) else $error("wait");
endmodule // lcd_regs_chk

bind lcd_contrast_seg_regs lcd_regs_chk u_chk (.core_clk, .rstn, .address,
   .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .ladder,
   .gpio_drive, .seg_level, .pin_in, .pad_drive, .gpio_in, .seg_pin_mask);

// ==== verification/tb.sv ====
// self-checking bench for the lcd contrast and segment enable bank
// assumes package, defs header and checker are compiled first
`timescale 1ns/1ps
`include "lcd_regs_defs.svh"

module tb;
   import lcd_regs_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, q;
   logic [1:0] response, r;
   logic waitrequest;
   ladder_s ladder;
   pin_drive_s gpio_drive = 96'h0;
   pin_drive_s pad_drive;
   logic [47:0] seg_level = 48'h0;
   logic [47:0] pin_in = 48'h0;
   logic [47:0] gpio_in, seg_pin_mask, m;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;

   always #2.5 core_clk = ~core_clk;

   lcd_contrast_seg_regs DUT (.core_clk, .rstn, .address, .read, .write,
      .byteenable, .writedata, .readdata, .response, .waitrequest, .ladder,
      .gpio_drive, .seg_level, .pin_in, .pad_drive, .gpio_in, .seg_pin_mask);

   // ==========================================================
   // shared tasks
   task automatic final_report();
      if (n_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [95:0] g, input logic [95:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] be);
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= wr;
      read <= !wr;
      @(posedge core_clk);
      while (waitrequest !== 1'b0) @(posedge core_clk);
      q = readdata;
      r = response;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge core_clk);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_contrast();
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 8'h00, 32'hFFFFFFF8 | 32'(c), 4'hF);
         chk(ladder, {c == 0, 7'((1 << c) - 1)});
         bus(1'b0, 8'h00, 32'h0, 4'hF);
         chk(q, 32'(c));
      end
      bus(1'b1, 8'h00, 32'h0, 4'h0);
      chk(ladder, 8'h7F);
      bus(1'b0, 8'hFC, 32'h0, 4'hF);
      chk({r, q}, {2'h3, 32'h0});
   endtask

   task automatic t_seg();
      m = 48'h0;
      for (int i = 0; i < 6; i++) begin
         m[8*i +: 8] = 8'hA5 ^ 8'(i * 17);
         bus(1'b1, 8'h10 + 8'(4 * i), 32'(m[8*i +: 8]), 4'hF);
      end
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 8'h10 + 8'(4 * i), 32'h0, 4'hF);
         chk({r, q}, {2'h0, 32'(m[8*i +: 8])});
      end
      chk(seg_pin_mask, m);
      gpio_drive <= {48'h123456789ABC, 48'hF0F0F0F0F0F0};
      seg_level <= 48'hFFFF0000FFFF;
      pin_in <= 48'hAAAA5555CCCC;
      @(posedge core_clk);
      chk(pad_drive.out, (seg_level & m) | (gpio_drive.out & ~m));
      chk(pad_drive.oe_n, gpio_drive.oe_n & ~m);
      chk(gpio_in, pin_in & ~m);
      // status is read only: code seven taps, 24 segment pins in m
      bus(1'b1, 8'h04, 32'hFFFFFFFF, 4'hF);
      bus(1'b0, 8'h04, 32'h0, 4'hF);
      chk({r, q}, {2'h0, 32'h0000187F});
   endtask

   // a second reset clears the contrast code and segment enables, ladder back to shorted, pins fall back to gpio
   task automatic t_rerun();
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(ladder, 8'h80);
      chk(pad_drive, gpio_drive);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 8'h10 + 8'(4 * i), 32'h0, 4'hF);
         chk(q, 32'h0);
      end
      bus(1'b0, 8'h00, 32'h0, 4'hF);
      chk(q, 32'h0);
   endtask

   // ==========================================================
   // main sequence and timeout
   initial begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(ladder, 8'h80);
      t_contrast();
      t_seg();
      t_rerun();
      final_report();
   end

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_errors++;
         final_report();
      end
   end
endmodule // tb
